// ### src/timed_irq_pkg.sv
// constants, register map and modes of the delayed and clock alarm block
package timed_irq_pkg;

  // clock and time base
  localparam int unsigned SYS_CLK_HZ = 10_000_000;
  localparam int unsigned DELAY_TICK_US = 1000;
  localparam int unsigned MS_CYCLES = SYS_CLK_HZ / 1_000_000 * DELAY_TICK_US;
  localparam int unsigned SECOND_MS = 1000;
  localparam int unsigned DELAY_W = 16;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DELAY = 8'h04;
  localparam logic [7:0] OFS_TOD = 8'h08;
  localparam logic [7:0] OFS_ALARM = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_DONE = 8'h14;

  // control register fields
  localparam int unsigned CTRL_W = 8;
  localparam int unsigned CTRL_IBZERO = 0;
  localparam int unsigned CTRL_TIMED_TOP = 1;
  localparam int unsigned CTRL_DELAY_LOADED = 2;
  localparam int unsigned CTRL_ALARM_LOADED = 3;
  localparam int unsigned CTRL_DELAY_DISABLE = 4;
  localparam int unsigned CTRL_DELAY_DEFER = 5;
  localparam int unsigned CTRL_ALARM_DISABLE = 6;
  localparam int unsigned CTRL_ALARM_DEFER = 7;
  localparam logic [7:0] CTRL_RESET = 8'h03;

  // status register fields
  localparam int unsigned ST_DELAY_ARMED = 0;
  localparam int unsigned ST_DELAY_PEND = 1;
  localparam int unsigned ST_DELAY_RUN = 2;
  localparam int unsigned ST_ALARM_ARMED = 3;
  localparam int unsigned ST_ALARM_PEND = 4;
  localparam int unsigned ST_ALARM_RUN = 5;

  // done register fields
  localparam int unsigned DONE_DELAY = 0;
  localparam int unsigned DONE_ALARM = 1;

  // input byte zero lines
  localparam int unsigned IBZ_DELAY = 0;
  localparam int unsigned IBZ_ALARM = 1;
  localparam int unsigned IBZ_LINES = 2;

  // operating mode of the controller
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_STOP,
    MODE_STARTUP,
    MODE_POWERDOWN
  } mode_type;

endpackage

// ### src/tick_divider.sv
// enable divider producing a one-cycle tick every DIV enables
`timescale 1ns/1ps
`default_nettype none

module tick_divider #(
  parameter int unsigned DIV = 10
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic enable,
  output logic tick
);

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  generate
    if (DIV < 1)
    begin : g_bad
      $error("tick_divider: DIV must be at least 1");
    end
  endgenerate

  logic [CW-1:0] count_q;
  wire atLast = (count_q == LAST);

  // tick on the enable that closes a period
  assign tick = enable && atLast;

  // period counter, advanced only by enable
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      count_q <= '0;
    else if (enable)
      count_q <= atLast ? '0 : count_q + CW'(1);
  end

endmodule // tick_divider

`default_nettype wire

// ### src/timed_interrupts.sv
// delayed interrupt and clock alarm engine with apb registers
//
// Behaviour
// R1: timed sources generated only while input byte zero mode is off
// R2: with that mode on, input byte zero events feed both handlers
// R3: delay counts in 1 ms steps; handler invoked exactly once
// R4: delay arm write starts it; expiry suspends program, runs handler
// R5: no delayed handler loaded means expiry does not interrupt
// R6: timed level ranks highest by default, configurable
// R7: delayed handler has top priority inside the timed level
// R8: delayed expiries outside run mode are discarded
// R9: armed delay cleared on entering stop and on power off
// R10: re-arming delay cancels pending one, running handler continues
// R11: expiry while delayed handler runs is silently dropped
// R12: separate controls disable or defer delayed servicing
// R13: settable and readable time-of-day clock is the alarm base
// R14: alarm arm write sets time; match suspends program, runs handler
// R15: no alarm handler loaded means match does not interrupt
// R16: alarm lowest in level, preempted by delayed and cyclic work
// R17: alarms outside run mode are discarded
// R18: armed alarm survives warm restart and power cycle, not cold
// R19: re-arming alarm cancels pending one, running handler continues
// R20: delay decrements on 1 ms tick, expires on tick reaching zero
`timescale 1ns/1ps
`default_nettype none

module timed_interrupts #(
  parameter int unsigned MS_CYCLES = timed_irq_pkg::MS_CYCLES,
  parameter int unsigned SECOND_MS = timed_irq_pkg::SECOND_MS,
  parameter int unsigned DELAY_W = timed_irq_pkg::DELAY_W
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire timed_irq_pkg::mode_type opMode,
  input wire logic coldRestart,
  input wire logic cyclicBusy,
  input wire logic [1:0] ibZeroIrq,
  output logic runDelayed,
  output logic runAlarm,
  output logic suspendProgram,
  output logic timedLevelTop
);

  generate
    if (DELAY_W < 2 || DELAY_W > 32 || MS_CYCLES < 1 || SECOND_MS < 1)
    begin : g_bad
      $error("timed_interrupts: unsupported parameter values");
    end
  endgenerate

  localparam logic [DELAY_W-1:0] COUNT_ONE = DELAY_W'(1);

  logic [timed_irq_pkg::CTRL_W-1:0] ctrl_q;
  logic [DELAY_W-1:0] delayCount_q;
  logic delayArmed_q;
  logic delayPend_q;
  logic delayRun_q;
  logic [31:0] tod_q;
  logic [31:0] alarmTime_q;
  logic alarmArmed_q;
  logic alarmPend_q;
  logic alarmRun_q;
  logic [31:0] prdata_q;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] sync3_q;
  logic [1:0] ibLevel_q;
  logic msTick;
  logic secTick;

  // apb decode
  wire access = psel && penable;
  wire setup = psel && !penable;
  wire hitCtrl = (paddr == timed_irq_pkg::OFS_CTRL);
  wire hitDelay = (paddr == timed_irq_pkg::OFS_DELAY);
  wire hitTod = (paddr == timed_irq_pkg::OFS_TOD);
  wire hitAlarm = (paddr == timed_irq_pkg::OFS_ALARM);
  wire hitStatus = (paddr == timed_irq_pkg::OFS_STATUS);
  wire hitDone = (paddr == timed_irq_pkg::OFS_DONE);
  wire hitAny = hitCtrl || hitDelay || hitTod || hitAlarm || hitStatus
    || hitDone;
  wire wrOk = access && pwrite && hitAny;
  wire wrCtrl = wrOk && hitCtrl;
  wire wrDelay = wrOk && hitDelay;
  wire wrTod = wrOk && hitTod;
  wire wrAlarm = wrOk && hitAlarm;
  wire wrDone = wrOk && hitDone;

  assign pready = 1'b1;
  assign pslverr = access && !hitAny;
  assign prdata = prdata_q;

  // control fields
  wire ibZeroMode = ctrl_q[timed_irq_pkg::CTRL_IBZERO];
  wire timedEnable = !ibZeroMode;
  wire delayLoaded = ctrl_q[timed_irq_pkg::CTRL_DELAY_LOADED];
  wire alarmLoaded = ctrl_q[timed_irq_pkg::CTRL_ALARM_LOADED];
  wire delayDisable = ctrl_q[timed_irq_pkg::CTRL_DELAY_DISABLE];
  wire delayDefer = ctrl_q[timed_irq_pkg::CTRL_DELAY_DEFER];
  wire alarmDisable = ctrl_q[timed_irq_pkg::CTRL_ALARM_DISABLE];
  wire alarmDefer = ctrl_q[timed_irq_pkg::CTRL_ALARM_DEFER];

  // operating mode decode
  wire inRun = (opMode == timed_irq_pkg::MODE_RUN);
  wire stopLike = (opMode == timed_irq_pkg::MODE_STOP)
    || (opMode == timed_irq_pkg::MODE_POWERDOWN);

  // handler completion strobes from software
  wire doneDelayed = wrDone && pwdata[timed_irq_pkg::DONE_DELAY];
  wire doneAlarm = wrDone && pwdata[timed_irq_pkg::DONE_ALARM];

  // 1 ms tick and 1 s tick from the system clock
  tick_divider #(
    .DIV(MS_CYCLES)
  ) u_ms_div (
    .sys_clk(sys_clk),
    .reset(reset),
    .enable(1'b1),
    .tick(msTick)
  );

  tick_divider #(
    .DIV(SECOND_MS)
  ) u_sec_div (
    .sys_clk(sys_clk),
    .reset(reset),
    .enable(msTick),
    .tick(secTick)
  );

  // input byte zero lines: three stages, change taken when 2 and 3 agree
  genvar gi;
  generate
    for (gi = 0; gi < timed_irq_pkg::IBZ_LINES; gi++)
    begin : g_ibz
      always_ff @(posedge sys_clk or posedge reset)
      begin
        if (reset)
        begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
          ibLevel_q[gi] <= 1'b0;
        end
        else
        begin
          sync1_q[gi] <= ibZeroIrq[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (sync2_q[gi] == sync3_q[gi])
            ibLevel_q[gi] <= sync3_q[gi];
        end
      end
    end
  endgenerate

  // rising edges of the filtered input byte zero lines
  wire [1:0] ibRise = {sync3_q[1] && sync2_q[1] && !ibLevel_q[1],
    sync3_q[0] && sync2_q[0] && !ibLevel_q[0]};

  // delay expiry on the tick that takes the count to zero
  wire delayLast = (delayCount_q <= COUNT_ONE);
  wire delayExpire = msTick && delayArmed_q && delayLast && !wrDelay
    && !stopLike; // R20
  wire delayGen = delayExpire && timedEnable; // R1

  // event source: timer or input byte zero
  wire delayEvent = ibZeroMode ? ibRise[timed_irq_pkg::IBZ_DELAY]
    : delayGen; // R2
  wire delayAccept = delayEvent && inRun // R8
    && delayLoaded // R5
    && !delayDisable // R12
    && !delayRun_q; // R11
  wire delayStart = delayPend_q && !delayRun_q && !delayDefer // R12
    && inRun;

  // time-of-day match against armed alarm
  wire alarmMatch = alarmArmed_q && (tod_q == alarmTime_q) && !wrAlarm;
  wire alarmGen = alarmMatch && timedEnable; // R1
  wire alarmEvent = ibZeroMode ? ibRise[timed_irq_pkg::IBZ_ALARM]
    : alarmGen; // R2
  wire alarmAccept = alarmEvent && inRun // R17
    && alarmLoaded // R15
    && !alarmDisable
    && !alarmRun_q;
  wire alarmStart = alarmPend_q && !alarmRun_q && !alarmDefer && inRun
    && !delayRun_q && !delayPend_q && !cyclicBusy; // R16

  // control register
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      ctrl_q <= timed_irq_pkg::CTRL_RESET;
    else if (wrCtrl)
      ctrl_q <= pwdata[timed_irq_pkg::CTRL_W-1:0];
  end

  // delay arm, count down and clear on stop or power off
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      delayArmed_q <= 1'b0;
      delayCount_q <= '0;
    end
    else if (wrDelay)
    begin
      delayArmed_q <= 1'b1; // R4
      delayCount_q <= pwdata[DELAY_W-1:0]; // R3
    end
    else if (stopLike)
      delayArmed_q <= 1'b0; // R9
    else if (msTick && delayArmed_q)
    begin
      if (delayLast)
        delayArmed_q <= 1'b0; // R3
      else
        delayCount_q <= delayCount_q - COUNT_ONE; // R20
    end
  end

  // pending delayed request, one at most, set wins over clear
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      delayPend_q <= 1'b0;
    else if (!inRun)
      delayPend_q <= 1'b0; // R8
    else if (delayAccept)
      delayPend_q <= 1'b1;
    else if (delayStart || wrDelay)
      delayPend_q <= 1'b0; // R10
  end

  // delayed handler running until software reports done
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      delayRun_q <= 1'b0;
    else if (!inRun)
      delayRun_q <= 1'b0;
    else if (delayStart)
      delayRun_q <= 1'b1; // R4
    else if (doneDelayed)
      delayRun_q <= 1'b0;
  end

  // time-of-day clock, set by software, advanced each second
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      tod_q <= '0;
    else if (wrTod)
      tod_q <= pwdata; // R13
    else if (secTick)
      tod_q <= tod_q + 32'h0000_0001; // R13
  end

  // alarm arm, survives mode changes, cleared by cold restart
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      alarmArmed_q <= 1'b0;
      alarmTime_q <= '0;
    end
    else if (wrAlarm)
    begin
      alarmArmed_q <= 1'b1; // R14
      alarmTime_q <= pwdata;
    end
    else if (coldRestart)
      alarmArmed_q <= 1'b0; // R18
    else if (alarmMatch)
      alarmArmed_q <= 1'b0;
  end

  // pending alarm request, one at most, set wins over clear except cold restart
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      alarmPend_q <= 1'b0;
    else if (!inRun || coldRestart)
      alarmPend_q <= 1'b0; // R17
    else if (alarmAccept)
      alarmPend_q <= 1'b1;
    else if (alarmStart || wrAlarm)
      alarmPend_q <= 1'b0; // R19
  end

  // alarm handler running until software reports done
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      alarmRun_q <= 1'b0;
    else if (!inRun)
      alarmRun_q <= 1'b0;
    else if (alarmStart)
      alarmRun_q <= 1'b1; // R14
    else if (doneAlarm)
      alarmRun_q <= 1'b0;
  end

  // handler outputs: delayed preempts alarm, cyclic work suspends alarm
  assign runDelayed = delayRun_q; // R7
  assign runAlarm = alarmRun_q && !delayRun_q && !cyclicBusy; // R16
  assign suspendProgram = runDelayed || runAlarm; // R4
  assign timedLevelTop = ctrl_q[timed_irq_pkg::CTRL_TIMED_TOP]; // R6

  // status word
  logic [31:0] statusWord;
  always_comb
  begin
    statusWord = '0;
    statusWord[timed_irq_pkg::ST_DELAY_ARMED] = delayArmed_q;
    statusWord[timed_irq_pkg::ST_DELAY_PEND] = delayPend_q;
    statusWord[timed_irq_pkg::ST_DELAY_RUN] = delayRun_q;
    statusWord[timed_irq_pkg::ST_ALARM_ARMED] = alarmArmed_q;
    statusWord[timed_irq_pkg::ST_ALARM_PEND] = alarmPend_q;
    statusWord[timed_irq_pkg::ST_ALARM_RUN] = alarmRun_q;
  end

  // read mux, selected during the setup phase
  wire [31:0] readMux =
    hitCtrl ? {{(32 - timed_irq_pkg::CTRL_W){1'b0}}, ctrl_q} :
    hitDelay ? {{(32 - DELAY_W){1'b0}}, delayCount_q} :
    hitTod ? tod_q :
    hitAlarm ? alarmTime_q :
    hitStatus ? statusWord :
    32'h0000_0000;

  // read data register
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      prdata_q <= '0;
    else if (setup)
      prdata_q <= pwrite ? 32'h0000_0000 : readMux;
  end

endmodule // timed_interrupts

`default_nettype wire

// ### bench/timed_interrupts_props.sv
// port assertions for the timed interrupt block
`timescale 1ns/1ps
`default_nettype none

module timed_interrupts_props (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire timed_irq_pkg::mode_type opMode,
  input wire logic coldRestart,
  input wire logic cyclicBusy,
  input wire logic [1:0] ibZeroIrq,
  input wire logic runDelayed,
  input wire logic runAlarm,
  input wire logic suspendProgram,
  input wire logic timedLevelTop
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // bus answer always ready, error only in access
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access");
  // handler outputs and priority
  a_suspend_follows: assert property (
    suspendProgram == (runDelayed || runAlarm))
    else $error("suspend not tied to handlers");
  a_alarm_yields: assert property (
    runAlarm |-> !runDelayed && !cyclicBusy)
    else $error("alarm runs over higher work");
  a_delay_run_only: assert property (
    opMode != timed_irq_pkg::MODE_RUN |=> !runDelayed)
    else $error("delayed runs outside run");
  a_alarm_run_only: assert property (
    opMode != timed_irq_pkg::MODE_RUN |=> !runAlarm)
    else $error("alarm runs outside run");
  a_delay_rise_run: assert property (
    $rose(runDelayed) |-> $past(opMode) == timed_irq_pkg::MODE_RUN)
    else $error("delayed started outside run");
  a_top_follows: assert property (
    psel && penable && pwrite && paddr == timed_irq_pkg::OFS_CTRL
    |=> timedLevelTop == $past(pwdata[timed_irq_pkg::CTRL_TIMED_TOP]))
    else $error("priority flag not written");
  a_delay_holds: assert property (
    runDelayed && opMode == timed_irq_pkg::MODE_RUN
    && !(psel && penable && pwrite && paddr == timed_irq_pkg::OFS_DONE
    && pwdata[timed_irq_pkg::DONE_DELAY]) |=> runDelayed)
    else $error("delayed handler cut short");
endmodule // timed_interrupts_props

bind timed_interrupts timed_interrupts_props props (.sys_clk(sys_clk),
  .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .opMode(opMode), .coldRestart(coldRestart),
  .cyclicBusy(cyclicBusy), .ibZeroIrq(ibZeroIrq), .runDelayed(runDelayed),
  .runAlarm(runAlarm), .suspendProgram(suspendProgram),
  .timedLevelTop(timedLevelTop));

`default_nettype wire

// ### bench/delayed_and_clock_alarm_interrupts_tb.sv
// self-checking bench for the timed interrupt block
`timescale 1ns/1ps
`default_nettype none

module delayed_and_clock_alarm_interrupts_tb;
  localparam logic [7:0] aCtrl = timed_irq_pkg::OFS_CTRL;
  localparam logic [7:0] aDly = timed_irq_pkg::OFS_DELAY;
  localparam logic [7:0] aTod = timed_irq_pkg::OFS_TOD;
  localparam logic [7:0] aAlm = timed_irq_pkg::OFS_ALARM;
  localparam logic [7:0] aDone = timed_irq_pkg::OFS_DONE;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  timed_irq_pkg::mode_type opMode = timed_irq_pkg::MODE_RUN;
  logic coldRestart = 1'b0, cyclicBusy = 1'b0;
  logic [1:0] ibZeroIrq = 2'b00;
  logic runDelayed, runAlarm, suspendProgram, timedLevelTop;
  int errorCnt = 0, checksDone = 0;
  // register rows: address, write, read back, error
  logic [7:0] rowA [4] = '{8'h00, 8'h0C, 8'h18, 8'h14};
  logic [31:0] rowW [4] = '{32'h0000_000E, 32'h0000_1234, 32'h0000_5555,
    32'h0000_0003};
  logic [31:0] rowR [4] = '{32'h0000_000E, 32'h0000_1234, 32'h0000_0000,
    32'h0000_0000};
  logic rowE [4] = '{1'b0, 1'b0, 1'b1, 1'b0};

  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;

  timed_interrupts #(.MS_CYCLES(10), .SECOND_MS(4)) dut (.sys_clk(sys_clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .opMode(opMode), .coldRestart(coldRestart),
    .cyclicBusy(cyclicBusy), .ibZeroIrq(ibZeroIrq), .runDelayed(runDelayed),
    .runAlarm(runAlarm), .suspendProgram(suspendProgram),
    .timedLevelTop(timedLevelTop));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one apb transfer, held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      check(32'h0, 32'h1);
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // wait up to lim cycles for a handler, compare whether it started
  task automatic wait_hi(input int lim, input logic alm, input logic exp);
    int n = 0;
    logic s = 1'b0;
    while (n < lim && s !== 1'b1)
    begin
      @(posedge sys_clk);
      s = alm ? runAlarm : runDelayed;
      n++;
    end
    check({31'h0, s}, {31'h0, exp});
    // a handler that never came is a timeout: report and stop
    if (exp === 1'b1 && s !== 1'b1)
      end_of_test();
  endtask

  task automatic mode_for(input timed_irq_pkg::mode_type m, input int c);
    opMode <= m;
    repeat (c) @(posedge sys_clk);
    opMode <= timed_irq_pkg::MODE_RUN;
  endtask

  initial
  begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    apb(0, aCtrl, 0);
    check(rd, 32'h0000_0003);
    check({31'h0, timedLevelTop}, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      apb(1, rowA[i], rowW[i]);
      apb(0, rowA[i], 0);
      check(rd, rowR[i]);
      check({31'h0, err}, {31'h0, rowE[i]});
    end
    apb(1, aCtrl, 32'h0000_000C);
    @(posedge sys_clk);
    check({31'h0, timedLevelTop}, 32'h0);
    apb(1, aCtrl, 32'h0000_000E);
    $display("registers done");
    // delay timing, re-arm while running, collision drop
    apb(1, aDly, 3);
    wait_hi(18, 0, 0);
    wait_hi(20, 0, 1);
    check({31'h0, suspendProgram}, 32'h1);
    apb(1, aDly, 1);
    repeat (30) @(posedge sys_clk);
    check({31'h0, runDelayed}, 32'h1);
    apb(1, aDone, 1);
    wait_hi(40, 0, 0);
    apb(1, aDly, 4);
    apb(1, aDly, 6);
    wait_hi(45, 0, 0);
    wait_hi(30, 0, 1);
    apb(1, aDone, 1);
    $display("delay done");
    // not loaded, disabled, deferred
    apb(1, aCtrl, 32'h0000_000A);
    apb(1, aDly, 1);
    wait_hi(30, 0, 0);
    apb(1, aCtrl, 32'h0000_001E);
    apb(1, aDly, 1);
    wait_hi(30, 0, 0);
    apb(1, aCtrl, 32'h0000_002E);
    apb(1, aDly, 1);
    wait_hi(30, 0, 0);
    apb(1, aCtrl, 32'h0000_000E);
    wait_hi(10, 0, 1);
    apb(1, aDone, 1);
    $display("servicing controls done");
    // stop clears armed delay, start-up discards expiry
    apb(1, aDly, 2);
    mode_for(timed_irq_pkg::MODE_STOP, 3);
    wait_hi(40, 0, 0);
    apb(1, aDly, 2);
    mode_for(timed_irq_pkg::MODE_POWERDOWN, 3);
    wait_hi(40, 0, 0);
    apb(1, aDly, 1);
    mode_for(timed_irq_pkg::MODE_STARTUP, 20);
    wait_hi(30, 0, 0);
    // input byte zero mode
    apb(1, aCtrl, 32'h0000_000F);
    apb(1, aDly, 1);
    wait_hi(30, 0, 0);
    ibZeroIrq <= 2'b01;
    repeat (5) @(posedge sys_clk);
    ibZeroIrq <= 2'b10;
    wait_hi(20, 0, 1);
    wait_hi(20, 1, 0);
    apb(1, aDone, 1);
    wait_hi(20, 1, 1);
    ibZeroIrq <= 2'b00;
    apb(1, aDone, 2);
    apb(1, aCtrl, 32'h0000_000E);
    $display("mode tests done");
    // alarm fire, cyclic preemption
    apb(1, aTod, 5);
    apb(1, aAlm, 7);
    wait_hi(120, 1, 1);
    cyclicBusy <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check({31'h0, runAlarm}, 32'h0);
    cyclicBusy <= 1'b0;
    wait_hi(5, 1, 1);
    apb(1, aDone, 2);
    // alarm in stop, cold restart, power cycle, re-arm
    apb(1, aTod, 0);
    apb(1, aAlm, 1);
    mode_for(timed_irq_pkg::MODE_STOP, 60);
    wait_hi(60, 1, 0);
    apb(1, aTod, 0);
    apb(1, aAlm, 2);
    coldRestart <= 1'b1;
    @(posedge sys_clk);
    coldRestart <= 1'b0;
    wait_hi(120, 1, 0);
    apb(1, aTod, 0);
    apb(1, aAlm, 3);
    mode_for(timed_irq_pkg::MODE_POWERDOWN, 3);
    wait_hi(160, 1, 1);
    apb(1, aDone, 2);
    apb(1, aTod, 0);
    apb(1, aAlm, 2);
    apb(1, aAlm, 200);
    wait_hi(150, 1, 0);
    // alarm handler not loaded, alarm disabled, alarm deferred
    apb(1, aCtrl, 32'h0000_0006);
    apb(1, aTod, 0);
    apb(1, aAlm, 1);
    wait_hi(60, 1, 0);
    apb(1, aCtrl, 32'h0000_004E);
    apb(1, aTod, 0);
    apb(1, aAlm, 1);
    wait_hi(60, 1, 0);
    apb(1, aCtrl, 32'h0000_008E);
    apb(1, aTod, 0);
    apb(1, aAlm, 1);
    wait_hi(60, 1, 0);
    apb(1, aCtrl, 32'h0000_000E);
    wait_hi(5, 1, 1);
    apb(1, aDone, 2);
    $display("alarm done");
    // reset in mid-run while the delayed handler is running
    apb(1, aDly, 1);
    wait_hi(30, 0, 1);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check({31'h0, runDelayed}, 32'h0);
    check({31'h0, suspendProgram}, 32'h0);
    reset <= 1'b0;
    apb(0, aCtrl, 0);
    check(rd, 32'h0000_0003);
    check({31'h0, timedLevelTop}, 32'h1);
    $display("reset done");
    end_of_test();
  end
endmodule // delayed_and_clock_alarm_interrupts_tb

`default_nettype wire
